// ===== hw/tdmcfg_pkg.sv
`default_nettype none
package tdmcfg_pkg;
    localparam int STREAMS         = 64;
    localparam int OFS_REGS        = 16;
    localparam int STREAMS_PER_REG = 4;
    localparam int OFS_FLD_W       = 4;
    localparam int OFS_DLE_BIT     = 0;
    localparam int OFS_WHOLE_LSB   = 1;
    localparam int OFS_WHOLE_W     = 3;
    localparam int HALF_STEP_W     = 4;
    localparam logic [HALF_STEP_W-1:0] MAX_HALF_STEPS = 4'hF;
    localparam logic [15:0] OFS_RESET = 16'h0000;

    localparam int CM_W            = 16;
    localparam int CM_MODE_LSB     = 14;
    localparam int CM_MODE_W       = 2;
    localparam int CM_STREAM_LSB   = 8;
    localparam int CM_STREAM_W     = 6;
    localparam int CM_CHAN_LSB     = 0;
    localparam int CM_CHAN_W       = 8;

    localparam int AXI_AW          = 12;
    localparam logic [AXI_AW-1:0] ADDR_OFS_BASE  = 12'h000;
    localparam logic [AXI_AW-1:0] ADDR_CTRL      = 12'h040;
    localparam logic [AXI_AW-1:0] ADDR_STATUS    = 12'h044;
    localparam logic [AXI_AW-1:0] ADDR_CONN_BASE = 12'h400;
    localparam int CONN_MAX        = 256;
    localparam int CTRL_EN_BIT     = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_STEP_LSB   = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CLK_PERIOD_NS   = 8;
    localparam int FP_LATENCY      = 2;

    typedef enum logic [1:0] {
        TDMCFG_MODE_VAR_DELAY   = 2'h0,
        TDMCFG_MODE_CONST_DELAY = 2'h1,
        TDMCFG_MODE_PROCESSOR   = 2'h2,
        TDMCFG_MODE_HIZ         = 2'h3
    } tdmcfg_mode_t;
endpackage
`default_nettype wire

// ===== hw/tdmcfg_ofs_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tdmcfg_ofs_if;
    import tdmcfg_pkg::*;
    logic [STREAMS*OFS_FLD_W-1:0] ofs_cfg;
    logic                         fp_edge;
    logic [STREAMS-1:0]           start;
    logic                         busy;
    logic [HALF_STEP_W-1:0]       half_step;

    modport cfg (output ofs_cfg, output fp_edge, input start, input busy, input half_step);
    modport tmr (input ofs_cfg, input fp_edge, output start, output busy, output half_step);
endinterface
`default_nettype wire

// ===== hw/tdmcfg_frame_offset.sv
`timescale 1ns/1ns
`default_nettype none
module tdmcfg_frame_offset
    import tdmcfg_pkg::*;
#(
    parameter int HALF_DIV = 4
)(
    input  wire logic   aclk,
    input  wire logic   aresetn,
    tdmcfg_ofs_if.tmr   ofs
);
    localparam int DW = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
    localparam logic [DW-1:0] DIV_LAST = DW'(HALF_DIV - 1);

    logic [DW-1:0]          div_r;
    logic [HALF_STEP_W-1:0] step_r;
    logic                   busy_r;
    logic                   evt_r;
    logic                   half_tick;
    logic [STREAMS-1:0]     hit;

    // Divider restarts at the pulse so every half-period lands a fixed count after it
    assign half_tick = busy_r && (div_r == DIV_LAST);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_r  <= '0;
            step_r <= '0;
            busy_r <= 1'b0;
            evt_r  <= 1'b0;
        end
        else if (ofs.fp_edge)
        begin
            div_r  <= '0;
            step_r <= '0;
            busy_r <= 1'b1;
            evt_r  <= 1'b1;
        end
        else
        begin
            div_r  <= half_tick ? '0 : (busy_r ? div_r + 1'b1 : '0);
            step_r <= half_tick ? step_r + 1'b1 : step_r;
            busy_r <= busy_r && !(half_tick && (step_r == MAX_HALF_STEPS - 1'b1));
            evt_r  <= half_tick;
        end
    end

    // Offset field is {whole periods, half bit}: its value is the delay in half-periods
    for (genvar n = 0; n < STREAMS; n++)
    begin : g_stream
        assign hit[n] = evt_r && (step_r == ofs.ofs_cfg[n*OFS_FLD_W +: OFS_FLD_W]);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ofs.start <= '0;
        else
            ofs.start <= hit;
    end

    assign ofs.busy      = busy_r;
    assign ofs.half_step = step_r;
endmodule // tdmcfg_frame_offset
`default_nettype wire

// ===== hw/tdmcfg_top.sv
`timescale 1ns/1ns
`default_nettype none
module tdmcfg_top
    import tdmcfg_pkg::*;
#(
    parameter int CONN_DEPTH = 256,
    parameter int HALF_DIV   = 4
)(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [AXI_AW-1:0]             s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [AXI_AW-1:0]             s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          frame_pulse_in,
    input  wire logic [$clog2(CONN_DEPTH)-1:0] conn_sel_chan,
    output logic [STREAMS-1:0]                 stream_frame_start,
    output tdmcfg_mode_t                       switching_mode_select,
    output logic [CM_STREAM_W-1:0]             source_stream_select,
    output logic [CM_CHAN_W-1:0]               source_channel_select,
    output logic                               conn_out_hiz
);
    localparam int CIW = $clog2(CONN_DEPTH);
    localparam logic [8:0] CONN_LIM = 9'(CONN_DEPTH);

    if (CONN_DEPTH < 2 || CONN_DEPTH > CONN_MAX)
        $error("CONN_DEPTH must lie in 2..256");
    if (HALF_DIV < 1 || HALF_DIV > 255)
        $error("HALF_DIV must lie in 1..255");

    // Register storage
    logic [15:0]      stream_offset_cfg_r [OFS_REGS];
    logic [CM_W-1:0]  conn_mem [CONN_DEPTH];
    logic [31:0]      ctrl_r;

    // AXI write side
    logic [AXI_AW-1:0] wa_r;
    logic              wa_held_r;
    logic [31:0]       wd_r;
    logic [3:0]        ws_r;
    logic              wd_held_r;
    logic              wr_go;
    logic              wr_is_ofs;
    logic              wr_is_ctrl;
    logic              wr_is_stat;
    logic              wr_is_conn;
    logic [3:0]        wr_ofs_idx;
    logic [CIW-1:0]    wr_conn_idx;

    assign wr_go       = wa_held_r && wd_held_r && !s_axi_bvalid;
    assign wr_ofs_idx  = wa_r[5:2];
    assign wr_conn_idx = wa_r[CIW+1:2];
    assign wr_is_ofs   = (wa_r[AXI_AW-1:6] == ADDR_OFS_BASE[AXI_AW-1:6]);
    assign wr_is_ctrl  = ({wa_r[AXI_AW-1:2], 2'b00} == ADDR_CTRL);
    assign wr_is_stat  = ({wa_r[AXI_AW-1:2], 2'b00} == ADDR_STATUS);
    assign wr_is_conn  = (wa_r[11:10] == ADDR_CONN_BASE[11:10]) && ({1'b0, wa_r[9:2]} < CONN_LIM);

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wa_held_r     <= 1'b0;
            wd_held_r     <= 1'b0;
            wa_r          <= '0;
            wd_r          <= '0;
            ws_r          <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !wa_held_r && !(s_axi_awvalid && s_axi_awready) && !wr_go;
            s_axi_wready  <= !wd_held_r && !(s_axi_wvalid && s_axi_wready) && !wr_go;
            if (s_axi_awvalid && s_axi_awready)
            begin
                wa_r      <= s_axi_awaddr;
                wa_held_r <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wd_r      <= s_axi_wdata;
                ws_r      <= s_axi_wstrb;
                wd_held_r <= 1'b1;
            end
            if (wr_go)
            begin
                wa_held_r    <= 1'b0;
                wd_held_r    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_is_ofs || wr_is_ctrl || wr_is_stat || wr_is_conn) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Four streams per offset word, each nibble {whole periods, half bit}
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < OFS_REGS; i++)
                stream_offset_cfg_r[i] <= OFS_RESET;
            ctrl_r <= CTRL_RESET;
        end
        else if (wr_go && wr_is_ofs)
            stream_offset_cfg_r[wr_ofs_idx] <= merge16(stream_offset_cfg_r[wr_ofs_idx], wd_r, ws_r);
        else if (wr_go && wr_is_ctrl && ws_r[0])
            ctrl_r[CTRL_EN_BIT] <= wd_r[CTRL_EN_BIT];
    end

    // Connection memory is bulk data, not control: left unreset to stay in plain RAM
    always_ff @(posedge aclk)
    begin
        if (wr_go && wr_is_conn)
            conn_mem[wr_conn_idx] <= merge16(conn_mem[wr_conn_idx], wd_r, ws_r);
    end

    // Frame offset timing
    tdmcfg_ofs_if ofs_if ();

    logic fp_sync1_r;
    logic fp_sync2_r;
    logic fp_prev_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fp_sync1_r <= 1'b0;
            fp_sync2_r <= 1'b0;
            fp_prev_r  <= 1'b0;
        end
        else
        begin
            fp_sync1_r <= frame_pulse_in;
            fp_sync2_r <= fp_sync1_r;
            fp_prev_r  <= fp_sync2_r;
        end
    end

    assign ofs_if.fp_edge = fp_sync2_r && !fp_prev_r && ctrl_r[CTRL_EN_BIT];

    for (genvar n = 0; n < STREAMS; n++)
    begin : g_ofs
        assign ofs_if.ofs_cfg[n*OFS_FLD_W +: OFS_FLD_W] =
            stream_offset_cfg_r[n / STREAMS_PER_REG][(n % STREAMS_PER_REG)*OFS_FLD_W +: OFS_FLD_W];
    end

    tdmcfg_frame_offset #(
        .HALF_DIV (HALF_DIV)
    ) u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ofs     (ofs_if)
    );

    assign stream_frame_start = ofs_if.start;

    // Datapath lookup of one output channel's connection word
    logic [CM_W-1:0] sel_word;
    assign sel_word = conn_mem[conn_sel_chan];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            switching_mode_select <= TDMCFG_MODE_HIZ;
            source_stream_select  <= '0;
            source_channel_select <= '0;
            conn_out_hiz          <= 1'b1;
        end
        else
        begin
            switching_mode_select <= tdmcfg_mode_t'(sel_word[CM_MODE_LSB +: CM_MODE_W]);
            source_stream_select  <= sel_word[CM_STREAM_LSB +: CM_STREAM_W];
            source_channel_select <= sel_word[CM_CHAN_LSB +: CM_CHAN_W];
            conn_out_hiz          <= (sel_word[CM_MODE_LSB +: CM_MODE_W] == TDMCFG_MODE_HIZ);
        end
    end

    // AXI read side
    logic [31:0] rd_mux;
    logic        rd_ok;
    logic [15:0] rd_ofs_word;
    logic [15:0] rd_conn_word;
    logic [31:0] status_word;

    assign rd_ofs_word  = stream_offset_cfg_r[s_axi_araddr[5:2]];
    assign rd_conn_word = conn_mem[s_axi_araddr[CIW+1:2]];
    assign status_word  = {24'h0, ofs_if.half_step, 3'h0, ofs_if.busy};

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (s_axi_araddr[AXI_AW-1:6] == ADDR_OFS_BASE[AXI_AW-1:6])
            rd_mux = {16'h0000, rd_ofs_word};
        else if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == ADDR_CTRL)
            rd_mux = ctrl_r;
        else if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == ADDR_STATUS)
            rd_mux = status_word;
        else if (s_axi_araddr[11:10] == ADDR_CONN_BASE[11:10] && {1'b0, s_axi_araddr[9:2]} < CONN_LIM)
            rd_mux = {16'h0000, rd_conn_word};
        else
            rd_ok = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Checking helpers: cycles since the last accepted frame pulse
    localparam logic [15:0] HD16   = 16'(HALF_DIV);
    localparam logic [15:0] LAT16  = 16'(FP_LATENCY);
    logic [15:0] since_fp_r;
    logic [3:0]  ofs0;
    logic [3:0]  ofs1;
    logic [3:0]  ofs2;
    logic [3:0]  ofs5;
    logic [CONN_DEPTH-1:0] conn_wr_r;

    assign ofs0 = ofs_if.ofs_cfg[0 +: OFS_FLD_W];
    assign ofs1 = ofs_if.ofs_cfg[1*OFS_FLD_W +: OFS_FLD_W];
    assign ofs2 = ofs_if.ofs_cfg[2*OFS_FLD_W +: OFS_FLD_W];
    assign ofs5 = ofs_if.ofs_cfg[5*OFS_FLD_W +: OFS_FLD_W];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            since_fp_r <= 16'hFFFF;
        else if (ofs_if.fp_edge)
            since_fp_r <= 16'h0001;
        else if (since_fp_r != 16'hFFFF)
            since_fp_r <= since_fp_r + 16'h0001;
    end

    // Connection memory powers up unknown, so a lookup is only checked once its entry was written
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            conn_wr_r <= '0;
        else if (wr_go && wr_is_conn)
            conn_wr_r[wr_conn_idx] <= 1'b1;
    end

    property p_mode_field;
        @(posedge aclk) disable iff (!aresetn)
        conn_wr_r[conn_sel_chan] |=>
            (switching_mode_select == $past(sel_word[15:14]))
            && (conn_out_hiz == ($past(sel_word[15:14]) == 2'h3));
    endproperty
    a_mode_field: assert property (p_mode_field) else $error("mode field not taken from bits 15:14");

    property p_source_fields;
        @(posedge aclk) disable iff (!aresetn)
        conn_wr_r[conn_sel_chan] |=>
            {source_stream_select, source_channel_select} == $past(sel_word[13:0]);
    endproperty
    a_source_fields: assert property (p_source_fields) else $error("source fields misplaced");

    property p_zero_offset_start;
        @(posedge aclk) disable iff (!aresetn)
        (ofs_if.fp_edge && ofs2 == 4'h0) |-> ##2 stream_frame_start[2];
    endproperty
    a_zero_offset_start: assert property (p_zero_offset_start) else $error("stream 2 frame start missed");

    property p_max_offset;
        @(posedge aclk) disable iff (!aresetn)
        (|stream_frame_start) |-> since_fp_r <= 16'(15 * HALF_DIV) + LAT16;
    endproperty
    a_max_offset: assert property (p_max_offset) else $error("frame start later than 7.5 periods");

    property p_boundary;
        @(posedge aclk) disable iff (!aresetn)
        (stream_frame_start[1] && !ofs1[0]) |-> ((since_fp_r - LAT16) % (16'h0002 * HD16)) == 16'h0000;
    endproperty
    a_boundary: assert property (p_boundary) else $error("whole-period offset off the boundary");

    property p_half_step;
        @(posedge aclk) disable iff (!aresetn)
        (stream_frame_start[0] && ofs0[0]) |-> ((since_fp_r - LAT16) % (16'h0002 * HD16)) == HD16;
    endproperty
    a_half_step: assert property (p_half_step) else $error("half-period offset misplaced");

    property p_stream5_indep;
        @(posedge aclk) disable iff (!aresetn)
        stream_frame_start[5] |-> since_fp_r == {12'h000, ofs5} * HD16 + LAT16;
    endproperty
    a_stream5_indep: assert property (p_stream5_indep) else $error("stream 5 offset not its own");

    property p_shift_value;
        @(posedge aclk) disable iff (!aresetn)
        stream_frame_start[0] |-> since_fp_r == {12'h000, ofs0} * HD16 + LAT16;
    endproperty
    a_shift_value: assert property (p_shift_value) else $error("stream 0 shift wrong");

    c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
    c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
    c_half_start: cover property (@(posedge aclk) disable iff (!aresetn) stream_frame_start[0] && ofs0[0]);
    c_last_stream: cover property (@(posedge aclk) disable iff (!aresetn) stream_frame_start[63]);
    c_zero_start: cover property (@(posedge aclk) disable iff (!aresetn) stream_frame_start[2] && ofs2 == 4'h0);
endmodule // tdmcfg_top
`default_nettype wire

// ===== sim/tdmcfg_fp_src.sv
`timescale 1ns/1ns
`default_nettype none
module tdmcfg_fp_src (
    input  wire logic aclk,
    input  wire logic fire,
    output var logic  frame_pulse_in
);
    // The edge lands off the clock grid, as a real pin would, so the synchroniser is exercised
    initial frame_pulse_in = 1'b0;
    always @(posedge aclk)
    begin
        if (fire)
        begin
            #3 frame_pulse_in = 1'b1;
            repeat (3) @(posedge aclk);
            #3 frame_pulse_in = 1'b0;
        end
    end
endmodule // tdmcfg_fp_src
`default_nettype wire

// ===== sim/tdm_switch_connection_offset_cfg_test.sv
`timescale 1ns/1ns
`default_nettype none
module tdm_switch_connection_offset_cfg_test;
    import tdmcfg_pkg::*;
    localparam int CD = 16;
    localparam int HD = 2;
    logic                   aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire, fp;
    logic                   awready, wready, bvalid, arready, rvalid, hiz;
    logic [AXI_AW-1:0]      awaddr, araddr;
    logic [31:0]            wdata, rdata, rd, wd, seed;
    logic [3:0]             wstrb, st, off, off0;
    logic [1:0]             bresp, rresp, r;
    logic [$clog2(CD)-1:0]  sel, ch;
    logic [STREAMS-1:0]     starts;
    tdmcfg_mode_t           mode;
    logic [CM_STREAM_W-1:0] src_strm;
    logic [CM_CHAN_W-1:0]   src_chan;
    logic [15:0]            ofs_m [OFS_REGS];
    int                     n_fail, compares, cyc;
    int                     t_m [STREAMS];
    int                     c_m [STREAMS];

    tdmcfg_top #(.CONN_DEPTH(CD), .HALF_DIV(HD)) u_tdmcfg_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .frame_pulse_in(fp), .conn_sel_chan(sel), .stream_frame_start(starts),
        .switching_mode_select(mode), .source_stream_select(src_strm),
        .source_channel_select(src_chan), .conn_out_hiz(hiz)
    );
    tdmcfg_fp_src u_tdmcfg_fp_src (.aclk(aclk), .fire(fire), .frame_pulse_in(fp));

    initial aclk = 1'b0;
    always #4 aclk = ~aclk;

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        for (int n = 0; n < STREAMS; n++)
            if (starts[n] === 1'b1)
            begin
                t_m[n] = cyc;
                c_m[n] = c_m[n] + 1;
            end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic pulse_and_wait;
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (80) @(posedge aclk);
    endtask

    // Watchdog sized well above the few hundred cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        close_out();
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, fire} = '0;
        {awaddr, araddr, wdata, wstrb, sel, cyc} = '0;
        seed = 32'hDC6890B9;
        for (int n = 0; n < STREAMS; n++) c_m[n] = 0;
        for (int k = 0; k < OFS_REGS; k++) ofs_m[k] = 16'h0000;
        repeat (5) @(posedge aclk);
        #1;
        chk("mode_rst", 32'(mode), 32'h3);
        chk("hiz_rst", 32'(hiz), 32'h1);
        @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < OFS_REGS; k++)
        begin
            axi_rd(12'(4 * k), rd, r);
            chk("ofs_rst", rd, 32'h0);
        end
        axi_rd(ADDR_CTRL, rd, r);
        chk("ctrl_rst", rd, 32'h1);
        // Register 0 is fixed so zero, maximum and both half-bit settings all occur
        for (int k = 0; k < OFS_REGS; k++)
        begin
            seed = lfsr(seed);
            wd = (k == 0) ? 32'h0000F0E1 : seed;
            st = (k == 5) ? 4'h1 : 4'hF;
            axi_wr(12'(4 * k), wd, st, r);
            chk("ofs_bresp", 32'(r), 32'(RESP_OKAY));
            if (st[0]) ofs_m[k][7:0] = wd[7:0];
            if (st[1]) ofs_m[k][15:8] = wd[15:8];
        end
        for (int k = 0; k < OFS_REGS; k++)
        begin
            axi_rd(12'(4 * k), rd, r);
            chk("ofs_rd", rd, {16'h0000, ofs_m[k]});
        end
        axi_wr(12'h080, 32'h0000FFFF, 4'hF, r);
        chk("unmap_bresp", 32'(r), 32'(RESP_SLVERR));
        axi_rd(12'h080, rd, r);
        chk("unmap_rresp", 32'(r), 32'(RESP_SLVERR));
        chk("unmap_rdata", rd, 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            seed = lfsr(seed);
            ch = seed[$clog2(CD)-1:0];
            wd = {16'h0000, 2'(m), seed[13:8], seed[23:16]};
            axi_wr(ADDR_CONN_BASE + 12'(4 * ch), wd, 4'hF, r);
            axi_rd(ADDR_CONN_BASE + 12'(4 * ch), rd, r);
            chk("conn_rd", rd, wd);
            sel <= ch;
            repeat (2) @(posedge aclk);
            #1;
            chk("mode", 32'(mode), 32'(m));
            chk("hiz", 32'(hiz), 32'(m == 3));
            chk("src_strm", 32'(src_strm), 32'(wd[13:8]));
            chk("src_chan", 32'(src_chan), 32'(wd[7:0]));
        end
        // Absolute latency belongs to the synchroniser, so starts are compared against stream 0
        pulse_and_wait();
        off0 = ofs_m[0][3:0];
        for (int n = 0; n < STREAMS; n++)
        begin
            off = 4'(ofs_m[n / 4] >> (4 * (n % 4)));
            chk("start_cnt", 32'(c_m[n]), 32'h1);
            chk("start_t", 32'(t_m[n] - off * HD), 32'(t_m[0] - off0 * HD));
        end
        // Status is read-only: a finished window shows half-step 15 with busy clear
        axi_wr(ADDR_STATUS, 32'h0000_00FF, 4'hF, r);
        chk("stat_bresp", 32'(r), 32'(RESP_OKAY));
        axi_rd(ADDR_STATUS, rd, r);
        chk("stat_done", rd, 32'h0000_00F0);
        axi_wr(ADDR_CTRL, 32'h0, 4'h1, r);
        chk("ctrl_bresp", 32'(r), 32'(RESP_OKAY));
        axi_rd(ADDR_CTRL, rd, r);
        chk("ctrl_off", rd, 32'h0);
        pulse_and_wait();
        chk("start_off", 32'(c_m[0]), 32'h1);
        close_out();
    end
endmodule // tdm_switch_connection_offset_cfg_test
`default_nettype wire
